// ==== inc/fqr_pkg.sv ====
package fqr_pkg;

    // Byte offset width
    localparam int          FQR_OFS_W      = 7;

    // Reserved filler parameter layout
    localparam logic [7:0]  FQR_FILL_ID    = 8'hF0;
    localparam logic [7:0]  FQR_FILL_LEN   = 8'h0F;
    localparam logic [7:0]  FQR_FILL_BYTE  = 8'hFF;

    // SFDP carrying parameter layout
    localparam logic [7:0]  FQR_SFDP_ID    = 8'hA5;
    localparam logic [7:0]  FQR_SFDP_LEN   = 8'h50;

    // Common header offsets
    localparam logic [6:0]  FQR_OFS_ID     = 7'h00;
    localparam logic [6:0]  FQR_OFS_LEN    = 7'h01;
    localparam logic [6:0]  FQR_OFS_DATA   = 7'h02;

    // Basic flash parameter base in SFDP space
    localparam logic [15:0] FQR_SFDP_BASE  = 16'h1120;
    localparam int          FQR_BFP_BYTES  = 16;

    // Variant dependent bytes
    localparam logic [7:0]  FQR_D1B2_SDR   = 8'hF3;
    localparam logic [7:0]  FQR_D1B2_DDR   = 8'hF7;
    localparam logic [7:0]  FQR_D4B2_STD   = 8'h04;
    localparam logic [7:0]  FQR_D4B2_ENH   = 8'h80;
    localparam logic [3:0]  FQR_IDX_D1B2   = 4'h2;
    localparam logic [3:0]  FQR_IDX_D4B2   = 4'hE;

    // Latency code of the default row, limit 66 MHz
    localparam logic [1:0]  FQR_LAT_DEFAULT = 2'h0;

    // Fixed basic flash parameter bytes, dwords 1 to 4, index 0 first
    localparam logic [7:0] FQR_BFP [FQR_BFP_BYTES] = '{
        8'hE7, 8'hFF, 8'hF3, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'h1F,
        8'h44, 8'hEB, 8'h08, 8'h6B,
        8'h08, 8'h3B, 8'h04, 8'hBB
    };

    // Which parameter is being read
    typedef enum logic {
        FQR_SEL_FILL,
        FQR_SEL_SFDP
    } fqr_sel_e;

endpackage

// ==== design/fqr_rom.sv ====
`timescale 1ns/1ps
// Operation
// RULE1: Each parameter opens with an identifier byte then a length byte, and the next one starts at length location plus length plus one.
// RULE2: The filler parameter reads F0h, 0Fh, then FFh at offsets 02h to 10h.
// RULE3: The SFDP parameter reads A5h at offset 00h and 50h at offset 01h.
// RULE4: Basic flash data starts at offset 02h, which is SFDP address 1120h, so SFDP offset is query offset minus two.
// RULE5: Dword 1 byte 0 reads E7h.
// RULE6: Dword 1 byte 1 reads FFh, no uniform 4 KB erase.
// RULE7: Dword 1 byte 2 reads F3h without double data rate and F7h with it.
// RULE8: Dword 1 byte 3 reads FFh and dword 2 reads FFh FFh FFh 1Fh.
// RULE9: Dword 3 low bytes read 44h and EBh.
// RULE10: Dword 3 high bytes read 08h and 6Bh.
// RULE11: Dword 4 low bytes read 08h and 3Bh.
// RULE12: Dword 4 high bytes read 04h or 80h by latency table variant, then BBh.
// RULE13: Latency code 00b is the 66 MHz row that the cycle counts describe.
// RULE14: All bytes are constant apart from the variant bytes and no write alters them.
module fqr_rom
    import fqr_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 reset,
    input  wire logic                 ddr_variant,
    input  wire logic                 enhanced_latency_table,
    input  wire logic                 rd_req,
    input  wire logic                 rd_sel_sfdp,
    input  wire logic [FQR_OFS_W-1:0] rd_offset,
    output logic                      rd_valid,
    output logic [7:0]                rd_data,
    output logic                      rd_in_range,
    output logic [15:0]               rd_sfdp_addr
);

    // Whole module state
    typedef struct packed {
        logic        valid;
        logic [7:0]  data;
        logic        in_range;
        logic [15:0] sfdp_addr;
    } fqr_state_s;

    fqr_state_s state_q;
    fqr_state_s state_d;

    // Basic flash parameter bytes with variant bytes applied, one per entry of the table
    logic [7:0] bfp_byte [FQR_BFP_BYTES];

    // Only two entries differ by variant; strap-like inputs, expected static
    for (genvar i = 0; i < FQR_BFP_BYTES; i++) begin : g_bfp
        if (i == int'(FQR_IDX_D1B2)) begin : g_d1b2
            assign bfp_byte[i] = ddr_variant ? FQR_D1B2_DDR
                                             : FQR_D1B2_SDR; // RULE7
        end else if (i == int'(FQR_IDX_D4B2)) begin : g_d4b2
            // Cycle byte for the default latency row
            assign bfp_byte[i] = enhanced_latency_table ? FQR_D4B2_ENH
                                                        : FQR_D4B2_STD; // RULE12 RULE13
        end else begin : g_fix
            assign bfp_byte[i] = FQR_BFP[i]; // RULE5 RULE6 RULE8 RULE9 RULE10 RULE11
        end
    end

    // Byte lookup; no write path exists, so contents cannot change
    always_comb begin
        logic [FQR_OFS_W-1:0] rel;
        fqr_sel_e             sel;
        rel = rd_offset - FQR_OFS_DATA; // RULE4
        sel = rd_sel_sfdp ? FQR_SEL_SFDP : FQR_SEL_FILL;
        state_d = state_q;
        state_d.valid = rd_req;
        if (rd_req) begin
            state_d.data      = FQR_FILL_BYTE;
            state_d.in_range  = 1'b0;
            state_d.sfdp_addr = 16'h0000;
            case (sel)
                FQR_SEL_FILL: begin
                    state_d.in_range = rd_offset <= FQR_OFS_LEN + FQR_FILL_LEN[6:0]; // RULE1
                    if (rd_offset == FQR_OFS_ID) begin
                        state_d.data = FQR_FILL_ID; // RULE2
                    end else if (rd_offset == FQR_OFS_LEN) begin
                        state_d.data = FQR_FILL_LEN; // RULE2
                    end
                end
                FQR_SEL_SFDP: begin
                    state_d.in_range = rd_offset <= FQR_OFS_LEN + FQR_SFDP_LEN[6:0]; // RULE1
                    if (rd_offset == FQR_OFS_ID) begin
                        state_d.data = FQR_SFDP_ID; // RULE3
                    end else if (rd_offset == FQR_OFS_LEN) begin
                        state_d.data = FQR_SFDP_LEN; // RULE3
                    end else begin
                        // Later dwords lie outside this table and read FFh
                        if (rel < FQR_OFS_W'(FQR_BFP_BYTES)) begin
                            state_d.data = bfp_byte[rel[3:0]];
                        end
                        state_d.sfdp_addr = FQR_SFDP_BASE + 16'(rel); // RULE4
                    end
                end
                default: state_d.data = FQR_FILL_BYTE;
            endcase
        end
    end

    // Registered answer, one cycle after request
    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= '0;
        end else begin
            state_q <= state_d; // RULE14
        end
    end

    assign rd_valid     = state_q.valid;
    assign rd_data      = state_q.data;
    assign rd_in_range  = state_q.in_range;
    assign rd_sfdp_addr = state_q.sfdp_addr;

endmodule // fqr_rom

// ==== dv/fqr_host.sv ====
`timescale 1ns/1ps
// Host side: launches the ordered read just after each rising edge
module fqr_host
    import fqr_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic [8:0]           cmd,
    output logic                      rd_req = 1'b0,
    output logic                      rd_sel_sfdp = 1'b0,
    output logic [FQR_OFS_W-1:0]      rd_offset = 7'h00
);
    // Idle cycles still move select and offset, so stale values never help
    always @(posedge clock) begin
        {rd_req, rd_sel_sfdp, rd_offset} <= cmd;
    end
endmodule // fqr_host

// ==== dv/fqr_monitor.sv ====
`timescale 1ns/1ps
module fqr_monitor
    import fqr_pkg::*;
(
    input wire logic clock, reset, ddr_variant, enhanced_latency_table,
    input wire logic rd_req, rd_sel_sfdp, rd_valid, rd_in_range,
    input wire logic [FQR_OFS_W-1:0] rd_offset,
    input wire logic [7:0]  rd_data,
    input wire logic [15:0] rd_sfdp_addr
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Request aimed at the SFDP parameter
    wire sq = rd_req & rd_sel_sfdp;
    property p_fill; rd_req && !rd_sel_sfdp && rd_offset inside {[2:16]}
        |=> rd_data == 8'hFF; endproperty
    a_fill: assert property (p_fill) else $error("filler byte");
    property p_sid; sq && rd_offset == 0 |=> rd_data == 8'hA5; endproperty
    a_sid: assert property (p_sid) else $error("sfdp id");
    property p_addr; sq && rd_offset > 1
        |=> rd_sfdp_addr == 16'h111E + $past(rd_offset); endproperty
    a_addr: assert property (p_addr) else $error("sfdp address");
    property p_d0; sq && rd_offset == 2 |=> rd_data == 8'hE7; endproperty
    a_d0: assert property (p_d0) else $error("dword1 byte0");
    property p_ddr; sq && rd_offset == 4
        |=> rd_data == (ddr_variant ? 8'hF7 : 8'hF3); endproperty
    a_ddr: assert property (p_ddr) else $error("ddr byte");
    property p_dio; sq && rd_offset == 16
        |=> rd_data == (enhanced_latency_table ? 8'h80 : 8'h04); endproperty
    a_dio: assert property (p_dio) else $error("dual io cycles");
    property p_hold; !rd_req |=> $stable(rd_data) && !rd_valid; endproperty
    a_hold: assert property (p_hold) else $error("data moved");
    property p_rng; rd_req |=> rd_valid && rd_in_range ==
        ($past(rd_offset) <= ($past(rd_sel_sfdp) ? 81 : 16)); endproperty
    a_rng: assert property (p_rng) else $error("range flag");
    c_b2b: cover property (sq ##1 sq);
    c_fill: cover property (rd_req && !rd_sel_sfdp);
    c_gap: cover property (!rd_req ##1 rd_req);
endmodule // fqr_monitor
bind fqr_rom fqr_monitor mon (.*);

// ==== dv/fqr_rom_test.sv ====
`timescale 1ns/1ps
module fqr_rom_test;
    logic       clock = 0, reset = 1, ddr = 0, enh = 0, v, ir, rq, sl;
    logic [8:0] cmd = 0, p0 = 0, p1 = 0;
    logic [6:0] ofs;
    logic [7:0] d, ld = 0;
    logic [15:0] a;
    int fails = 0, num_checks = 0;
    logic [7:0] t [16] = '{8'hE7, 8'hFF, 8'hF3, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'h1F, 8'h44, 8'hEB, 8'h08, 8'h6B, 8'h08, 8'h3B, 8'h04, 8'hBB};
    fqr_host host (.clock(clock), .cmd(cmd), .rd_req(rq), .rd_sel_sfdp(sl),
        .rd_offset(ofs));
    fqr_rom dut (.clock(clock), .reset(reset), .ddr_variant(ddr),
        .enhanced_latency_table(enh), .rd_req(rq), .rd_sel_sfdp(sl),
        .rd_offset(ofs), .rd_valid(v), .rd_data(d), .rd_in_range(ir),
        .rd_sfdp_addr(a));
    // Reference byte for a parameter and offset
    function automatic logic [7:0] mdl(logic s, int o);
        if (o < 2) return s ? (o ? 8'h50 : 8'hA5) : (o ? 8'h0F : 8'hF0);
        if (!s || o > 17) return 8'hFF;
        if (o == 4) return ddr ? 8'hF7 : 8'hF3;
        if (o == 16) return enh ? 8'h80 : 8'h04;
        return t[o-2];
    endfunction
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Host pipeline adds a cycle, so results trail the order by two
    task step(logic [8:0] c);
        @(negedge clock);
        if (p1[8]) begin
            ld = mdl(p1[7], p1[6:0]);
            chk("valid", v, 1);
            // Split by region so each compare carries its own rules
            if (!p1[7] || p1[6:0] < 7'h02) begin
                chk("head", d, ld);
            end else if (p1[6:0] < 7'h0A) begin
                chk("dw12", d, ld);
            end else begin
                chk("dw34", d, ld);
            end
            chk("range", ir, p1[6:0] <= (p1[7] ? 81 : 16));
            chk("addr", a, p1[7] && p1[6:0] > 1 ? 16'h111E + p1[6:0]
                : 16'h0000);
        end else begin
            chk("idle", v, 0);
            chk("held", d, ld);
        end
        p1 = p0;
        p0 = c;
        cmd = c;
    endtask
    initial begin
        forever #20 clock = ~clock;
    end
    initial begin
        void'($urandom(32'h7963752d));
        repeat (6) @(negedge clock);
        reset = 0;
        // Every variant, every offset of both parameters, back to back
        for (int k = 0; k < 4; k++) begin
            {ddr, enh} = k[1:0];
            for (int i = 0; i < 256; i++) step({1'b1, i[7:0]});
            $display("sweep %0d done", k);
        end
        repeat (400) step(9'($urandom));
        repeat (2) step(0);
        $display("random done");
        report_and_stop;
    end
endmodule // fqr_rom_test
